// ===== cop_map.vh
`ifndef COP_MAP_VH
`define COP_MAP_VH

// ****************************************
// widths
// ****************************************
`define COP_ADDR_W        8
`define COP_DATA_W        16
`define COP_SMP_W         14
`define COP_FIFO_DEPTH    8
`define COP_FIFO_AW       3

// ****************************************
// register offsets
// ****************************************
`define COP_OFS_GAIN_OFFSET  8'h37
`define COP_OFS_OFFSET_COPY  8'h38
`define COP_OFS_PAT_HPF      8'h39
`define COP_OFS_GLOBAL_CTRL  8'h3d
`define COP_OFS_STATUS       8'h3e

// ****************************************
// reset values
// ****************************************
`define COP_RST_16        16'h0000
`define COP_RST_CTRL      3'h0
`define COP_RST_SMP       14'h0000
`define COP_RST_ACC       20'h00000
`define COP_LFSR_SEED     16'h0001

// ****************************************
// field positions
// ****************************************
`define COP_GAIN_HI       15
`define COP_GAIN_LO       11
`define COP_OFFSET_HI     9
`define COP_OFFSET_LO     0
`define COP_PRBS13_BIT    15
`define COP_PRBS14_BIT    14
`define COP_PRBS15_BIT    13
`define COP_PRBS16_BIT    12
`define COP_PAT13_HI      11
`define COP_PAT13_LO      9
`define COP_PAT14_HI      8
`define COP_PAT14_LO      6
`define COP_CORNER_HI     4
`define COP_CORNER_LO     1
`define COP_HPF_EN_BIT    0
`define COP_CTRL_GAIN_EN  0
`define COP_CTRL_OFS_EN   1
`define COP_CTRL_PAT_SEL  2

// ****************************************
// pattern codes and arithmetic
// ****************************************
`define COP_PAT_NORMAL    3'h0
`define COP_PAT_ZEROS     3'h1
`define COP_PAT_ONES      3'h2
`define COP_PAT_TOGGLE    3'h3
`define COP_PAT_RAMP      3'h4
`define COP_TOGGLE_A      14'h2aaa
`define COP_TOGGLE_B      14'h1555
`define COP_ALL_ONES      14'h3fff
`define COP_GAIN_FRAC     12
`define COP_SMP_MAX       32'sh00001fff
`define COP_SMP_MIN       -32'sh00002000
`define COP_SAT_HI        14'h1fff
`define COP_SAT_LO        14'h2000

`endif

// ===== cop_fifo.v
`default_nettype none

module cop_fifo #(
  parameter WIDTH = 56,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  input  wire             clk,
  input  wire             rst,
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data,
  output wire [AW:0]      count
);

  reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr_reg;
  reg [AW-1:0]    rd_ptr_reg;
  reg [AW:0]      count_reg;
  wire            push;
  wire            pop;

  assign in_ready  = (count_reg != DEPTH[AW:0]);
  assign out_valid = (count_reg != {(AW+1){1'b0}});
  assign out_data  = mem_reg[rd_ptr_reg];
  assign count     = count_reg;
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_ptr_reg <= {AW{1'b0}};
      rd_ptr_reg <= {AW{1'b0}};
      count_reg  <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr_reg + 1'b1;
      end
      if (push && !pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (pop && !push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end

  // storage needs no reset; empty slots are never read out as valid
  always @(posedge clk) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data;
    end
  end

endmodule

`default_nettype wire

// ===== cop_post_proc.v
`include "cop_map.vh"
`default_nettype none

module cop_post_proc (
  input  wire        core_clk,
  input  wire        rst,
  input  wire [7:0]  reg_addr,
  input  wire [15:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [15:0] reg_rdata,
  input  wire        in_valid,
  output reg         in_ready,
  input  wire [13:0] in_ch13,
  input  wire [13:0] in_ch14,
  input  wire [13:0] in_ch15,
  input  wire [13:0] in_ch16,
  output reg         out_valid,
  input  wire        out_ready,
  output reg  [13:0] out_ch13,
  output reg  [13:0] out_ch14,
  output reg  [13:0] out_ch15,
  output reg  [13:0] out_ch16
);

  // ****************************************
  // registers
  // ****************************************
  reg  [15:0]        gain_offset_reg;
  reg  [15:0]        offset_copy_reg;
  reg  [15:0]        pat_hpf_reg;
  reg  [2:0]         global_ctrl_reg;
  reg  [13:0]        xprev_reg [0:3];
  reg  signed [19:0] yprev_reg [0:3];
  reg  [15:0]        lfsr_reg;
  reg  [13:0]        ramp_reg;
  reg                stage_valid_reg;
  reg  [55:0]        stage_data_reg;

  wire [4:0]  last_channel_gain_code    = gain_offset_reg[`COP_GAIN_HI:`COP_GAIN_LO];
  wire [9:0]  last_channel_offset_value = gain_offset_reg[`COP_OFFSET_HI:`COP_OFFSET_LO];
  wire        global_gain_enable        = global_ctrl_reg[`COP_CTRL_GAIN_EN];
  wire        global_offset_enable      = global_ctrl_reg[`COP_CTRL_OFS_EN];
  wire        per_output_pattern_select = global_ctrl_reg[`COP_CTRL_PAT_SEL];
  wire        prbs_enable_out13         = pat_hpf_reg[`COP_PRBS13_BIT];
  wire        prbs_enable_out14         = pat_hpf_reg[`COP_PRBS14_BIT];
  wire        prbs_enable_out15         = pat_hpf_reg[`COP_PRBS15_BIT];
  wire        prbs_enable_out16         = pat_hpf_reg[`COP_PRBS16_BIT];
  wire [2:0]  pattern_code_out13        = pat_hpf_reg[`COP_PAT13_HI:`COP_PAT13_LO];
  wire [2:0]  pattern_code_out14        = pat_hpf_reg[`COP_PAT14_HI:`COP_PAT14_LO];
  wire [3:0]  highpass_corner_k         = pat_hpf_reg[`COP_CORNER_HI:`COP_CORNER_LO];
  wire        highpass_enable_group4    = pat_hpf_reg[`COP_HPF_EN_BIT];

  wire [13:0] in_smp [0:3];
  wire        accept;
  wire        fifo_in_ready;
  wire        fifo_out_valid;
  wire        fifo_out_ready;
  wire [55:0] fifo_out_data;
  wire [3:0]  fifo_count;

  assign in_smp[0] = in_ch13;
  assign in_smp[1] = in_ch14;
  assign in_smp[2] = in_ch15;
  assign in_smp[3] = in_ch16;
  assign accept    = in_valid && in_ready;

  // ****************************************
  // functions
  // ****************************************
  // gain multiplier, 10^(N/100) with twelve fraction bits
  function [13:0] gain_coef;
    input [4:0] n;
    begin
      case (n)
        5'h00: gain_coef = 14'h1000;
        5'h01: gain_coef = 14'h105f;
        5'h02: gain_coef = 14'h10c1;
        5'h03: gain_coef = 14'h1125;
        5'h04: gain_coef = 14'h118b;
        5'h05: gain_coef = 14'h11f4;
        5'h06: gain_coef = 14'h125f;
        5'h07: gain_coef = 14'h12cc;
        5'h08: gain_coef = 14'h133d;
        5'h09: gain_coef = 14'h13af;
        5'h0a: gain_coef = 14'h1425;
        5'h0b: gain_coef = 14'h149d;
        5'h0c: gain_coef = 14'h1518;
        5'h0d: gain_coef = 14'h1595;
        5'h0e: gain_coef = 14'h1616;
        5'h0f: gain_coef = 14'h169a;
        5'h10: gain_coef = 14'h1721;
        5'h11: gain_coef = 14'h17aa;
        5'h12: gain_coef = 14'h1838;
        5'h13: gain_coef = 14'h18c8;
        5'h14: gain_coef = 14'h195c;
        5'h15: gain_coef = 14'h19f3;
        5'h16: gain_coef = 14'h1a8e;
        5'h17: gain_coef = 14'h1b2c;
        5'h18: gain_coef = 14'h1bce;
        5'h19: gain_coef = 14'h1c74;
        5'h1a: gain_coef = 14'h1d1d;
        5'h1b: gain_coef = 14'h1dcb;
        5'h1c: gain_coef = 14'h1e7d;
        5'h1d: gain_coef = 14'h1f32;
        5'h1e: gain_coef = 14'h1fed;
        default: gain_coef = 14'h20ab;
      endcase
    end
  endfunction

  function [13:0] sat14;
    input signed [31:0] v;
    begin
      if (v > `COP_SMP_MAX) begin
        sat14 = `COP_SAT_HI;
      end else if (v < `COP_SMP_MIN) begin
        sat14 = `COP_SAT_LO;
      end else begin
        sat14 = v[13:0];
      end
    end
  endfunction

  // 1/(1+2^-k) taken as 1 - 2^-k + 2^-2k; error below 2^-3k
  function signed [19:0] hpf_step;
    input [13:0]        x;
    input [13:0]        xp;
    input signed [19:0] yp;
    input [3:0]         k;
    reg signed [19:0]   s;
    begin
      s = $signed({{6{x[13]}}, x}) - $signed({{6{xp[13]}}, xp}) + yp;
      hpf_step = s - (s >>> k) + (s >>> {k, 1'b0});
    end
  endfunction

  function [13:0] pat_word;
    input        sel;
    input        prbs_en;
    input [2:0]  code;
    input [13:0] data;
    input [13:0] prbs;
    input [13:0] ramp;
    begin
      if (!sel) begin
        pat_word = data;
      end else if (prbs_en) begin
        pat_word = prbs;
      end else begin
        case (code)
          `COP_PAT_ZEROS:  pat_word = `COP_RST_SMP;
          `COP_PAT_ONES:   pat_word = `COP_ALL_ONES;
          `COP_PAT_TOGGLE: pat_word = ramp[0] ? `COP_TOGGLE_B : `COP_TOGGLE_A;
          `COP_PAT_RAMP:   pat_word = ramp;
          default:         pat_word = data;
        endcase
      end
    end
  endfunction

  // ****************************************
  // sample processing
  // ****************************************
  reg signed [19:0] y_next [0:3];
  reg [13:0]        filt   [0:3];
  reg signed [31:0] prod;
  reg signed [31:0] adj;
  reg [13:0]        ch16_proc;
  reg [55:0]        stage_data_next;
  integer           i;
  integer           j;

  always @* begin
    for (i = 0; i < 4; i = i + 1) begin
      y_next[i] = hpf_step(in_smp[i], xprev_reg[i], yprev_reg[i], highpass_corner_k);
      if (highpass_enable_group4) begin
        filt[i] = sat14({{12{y_next[i][19]}}, y_next[i]});
      end else begin
        filt[i] = in_smp[i];
      end
    end
    prod = $signed({{18{filt[3][13]}}, filt[3]}) * $signed({18'h00000, gain_coef(last_channel_gain_code)});
    if (global_gain_enable) begin
      adj = prod >>> `COP_GAIN_FRAC;
    end else begin
      adj = $signed({{18{filt[3][13]}}, filt[3]});
    end
    // only the first offset copy is used; the second is stored and read back but never applied
    if (global_offset_enable) begin
      adj = adj + $signed({{22{last_channel_offset_value[9]}}, last_channel_offset_value});
    end
    ch16_proc = sat14(adj);
    stage_data_next = {
      pat_word(per_output_pattern_select, prbs_enable_out16, `COP_PAT_NORMAL, ch16_proc,
               lfsr_reg[13:0], ramp_reg),
      pat_word(per_output_pattern_select, prbs_enable_out15, `COP_PAT_NORMAL, filt[2],
               lfsr_reg[13:0], ramp_reg),
      pat_word(per_output_pattern_select, prbs_enable_out14, pattern_code_out14, filt[1],
               lfsr_reg[13:0], ramp_reg),
      pat_word(per_output_pattern_select, prbs_enable_out13, pattern_code_out13, filt[0],
               lfsr_reg[13:0], ramp_reg)};
  end

  // ****************************************
  // stage and filter state
  // ****************************************
  // one-entry stage halves throughput but keeps in_ready a flop
  wire stage_valid_next = (stage_valid_reg && !fifo_in_ready) || accept;

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      stage_valid_reg <= 1'b0;
      stage_data_reg  <= {4{`COP_RST_SMP}};
      in_ready        <= 1'b0;
      lfsr_reg        <= `COP_LFSR_SEED;
      ramp_reg        <= `COP_RST_SMP;
      for (j = 0; j < 4; j = j + 1) begin
        xprev_reg[j] <= `COP_RST_SMP;
        yprev_reg[j] <= `COP_RST_ACC;
      end
    end else begin
      stage_valid_reg <= stage_valid_next;
      in_ready        <= !stage_valid_next;
      if (accept) begin
        stage_data_reg <= stage_data_next;
        lfsr_reg       <= {lfsr_reg[14:0], lfsr_reg[15] ^ lfsr_reg[13] ^ lfsr_reg[12] ^ lfsr_reg[10]};
        ramp_reg       <= ramp_reg + 1'b1;
        for (j = 0; j < 4; j = j + 1) begin
          xprev_reg[j] <= in_smp[j];
          // bypass clears history so enabling starts from rest
          yprev_reg[j] <= highpass_enable_group4 ? y_next[j] : `COP_RST_ACC;
        end
      end
    end
  end

  // ****************************************
  // output buffer
  // ****************************************
  cop_fifo #(
    .WIDTH (56),
    .DEPTH (`COP_FIFO_DEPTH),
    .AW    (`COP_FIFO_AW)
  ) u_fifo (
    .clk       (core_clk),
    .rst       (rst),
    .in_valid  (stage_valid_reg),
    .in_ready  (fifo_in_ready),
    .in_data   (stage_data_reg),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (fifo_out_data),
    .count     (fifo_count)
  );

  assign fifo_out_ready = !out_valid || out_ready;

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      out_valid <= 1'b0;
      out_ch13  <= `COP_RST_SMP;
      out_ch14  <= `COP_RST_SMP;
      out_ch15  <= `COP_RST_SMP;
      out_ch16  <= `COP_RST_SMP;
    end else if (fifo_out_ready) begin
      out_valid <= fifo_out_valid;
      if (fifo_out_valid) begin
        {out_ch16, out_ch15, out_ch14, out_ch13} <= fifo_out_data;
      end
    end
  end

  // ****************************************
  // register port
  // ****************************************
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      gain_offset_reg <= `COP_RST_16;
      offset_copy_reg <= `COP_RST_16;
      pat_hpf_reg     <= `COP_RST_16;
      global_ctrl_reg <= `COP_RST_CTRL;
    end else if (reg_wr) begin
      case (reg_addr)
        `COP_OFS_GAIN_OFFSET: gain_offset_reg <= reg_wdata;
        `COP_OFS_OFFSET_COPY: offset_copy_reg <= reg_wdata;
        `COP_OFS_PAT_HPF:     pat_hpf_reg     <= reg_wdata;
        `COP_OFS_GLOBAL_CTRL: global_ctrl_reg <= reg_wdata[2:0];
        default:              global_ctrl_reg <= global_ctrl_reg;
      endcase
    end
  end

  reg [15:0] rd_mux;

  always @* begin
    case (reg_addr)
      `COP_OFS_GAIN_OFFSET: rd_mux = gain_offset_reg;
      `COP_OFS_OFFSET_COPY: rd_mux = offset_copy_reg;
      `COP_OFS_PAT_HPF:     rd_mux = pat_hpf_reg;
      `COP_OFS_GLOBAL_CTRL: rd_mux = {13'h0000, global_ctrl_reg};
      `COP_OFS_STATUS:      rd_mux = {9'h000, fifo_count, stage_valid_reg, out_valid, in_ready};
      default:              rd_mux = `COP_RST_16;
    endcase
  end

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= `COP_RST_16;
    end else begin
      reg_rdata <= reg_rd ? rd_mux : `COP_RST_16;
    end
  end

endmodule

`default_nettype wire

// ===== cop_post_proc_properties.sv
`default_nettype none
// ****************************************
// port checker
// ****************************************
module cop_post_proc_properties (
  input wire logic        core_clk,
  input wire logic        rst,
  input wire logic [7:0]  reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic        in_valid,
  input wire logic        in_ready,
  input wire logic        out_valid,
  input wire logic        out_ready,
  input wire logic [13:0] out_ch13,
  input wire logic [13:0] out_ch14,
  input wire logic [13:0] out_ch15,
  input wire logic [13:0] out_ch16
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  wire stored = reg_addr inside {8'h37, 8'h38, 8'h39};
  wire mapped = stored || reg_addr inside {8'h3d, 8'h3e};
  wire [55:0] beat = {out_ch13, out_ch14, out_ch15, out_ch16};

  a_reset_quiet: assert property (disable iff (1'b0) rst |-> !in_ready && !out_valid)
    else $error("outputs active during reset");
  a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 16'h0000)
    else $error("read data outside its read cycle");
  a_unmapped_zero: assert property (reg_rd && !mapped |=> reg_rdata == 16'h0000)
    else $error("unmapped read not zero");
  a_reg_readback: assert property ((reg_wr && stored) ##1 (reg_rd && $stable(reg_addr))
    |=> reg_rdata == $past(reg_wdata, 2))
    else $error("register readback differs from write");
  a_ctrl_readback: assert property ((reg_wr && reg_addr == 8'h3d) ##1
    (reg_rd && reg_addr == 8'h3d) |=> reg_rdata == {13'h0000, $past(reg_wdata[2:0], 2)})
    else $error("control readback wrong");
  a_accept_gap: assert property (in_valid && in_ready |=> !in_ready)
    else $error("two samples accepted back to back");
  a_out_hold: assert property (out_valid && !out_ready |=> out_valid && $stable(beat))
    else $error("output beat changed while stalled");
  a_out_bound: assert property (in_valid && in_ready && !out_valid |-> ##[1:3] out_valid)
    else $error("output not presented in time");

  c_accept: cover property (in_valid && in_ready);
  c_stall: cover property (out_valid && !out_ready);
  c_readback: cover property (reg_wr ##1 reg_rd);
endmodule

bind cop_post_proc cop_post_proc_properties u_props (.core_clk, .rst, .reg_addr, .reg_wdata,
  .reg_wr, .reg_rd, .reg_rdata, .in_valid, .in_ready, .out_valid, .out_ready, .out_ch13,
  .out_ch14, .out_ch15, .out_ch16);
`default_nettype wire

// ===== cop_sink_model.sv
`default_nettype none
// ****************************************
// downstream capture model
// ****************************************
module cop_sink_model (
  input  wire logic       core_clk,
  input  wire logic       rst,
  input  wire logic [1:0] sink_mode,
  output logic            out_ready
);
  timeunit 1ns;
  timeprecision 1ns;
  integer seed = 44129;
  // mode 1 stalls at random, mode 2 never takes a beat so the block's buffer fills
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      out_ready <= 1'b0;
    end else begin
      case (sink_mode)
        2'h0: out_ready <= 1'b1;
        2'h1: out_ready <= ($random(seed) & 3) != 0;
        default: out_ready <= 1'b0;
      endcase
    end
  end
endmodule
`default_nettype wire

// ===== cop_post_proc_test.sv
`default_nettype none
module cop_post_proc_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic        core_clk, rst, reg_wr, reg_rd, in_valid, in_ready, out_valid, out_ready;
  logic [7:0]  reg_addr;
  logic [15:0] reg_wdata, reg_rdata, lfsr, cfg [0:255];
  logic [13:0] in_ch13, in_ch14, in_ch15, in_ch16, out_ch13, out_ch14, out_ch15, out_ch16;
  logic [1:0]  sink_mode;
  logic [55:0] exp_q [$];
  logic [7:0]  regs [5] = '{8'h37, 8'h38, 8'h39, 8'h3d, 8'h3a};
  integer      bad_count, checks_done, seed;
  int          xp [4], yp [4], v [4], gains [4] = '{0, 1, 20, 31};
  int          s, ramp, t, ofs;

  cop_post_proc dut (.core_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .in_valid, .in_ready, .in_ch13, .in_ch14, .in_ch15, .in_ch16, .out_valid, .out_ready,
    .out_ch13, .out_ch14, .out_ch15, .out_ch16);
  cop_sink_model sink (.core_clk, .rst, .sink_mode, .out_ready);

  // ****************************************
  // helpers
  // ****************************************
  function automatic int sat(input int x);
    return x > 8191 ? 8191 : (x < -8192 ? -8192 : x);
  endfunction
  function automatic int coef(input int n);
    return $rtoi(4096.0 * (10.0 ** (n / 100.0)) + 0.5);
  endfunction
  task automatic check(input logic [55:0] seen, input logic [55:0] want);
    checks_done++;
    if (seen !== want) begin
      bad_count++;
      $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, want);
    end
  endtask
  task automatic end_sim;
    if (bad_count == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic hang_if(input int n);
    if (n >= 2000) begin
      bad_count++;
      end_sim;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    // an edge passes between two writes so the strobe is never set twice at once
    if (reg_wr) @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge core_clk);
    reg_wr    <= 1'b0;
    if (a inside {8'h37, 8'h38, 8'h39}) cfg[a] = d;
    if (a == 8'h3d) cfg[a] = d & 16'h0007;
  endtask
  task automatic rd(input logic [7:0] a);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge core_clk);
    reg_rd   <= 1'b0;
    #1 check(reg_rdata, cfg[a]);
  endtask
  task automatic send(input int n);
    for (int i = 0; i < n; i++) begin
      in_valid <= 1'b1;
      in_ch13  <= 14'($random(seed));
      in_ch14  <= 14'($random(seed));
      in_ch15  <= 14'($random(seed));
      in_ch16  <= 14'($random(seed));
      t = 0;
      do begin
        @(posedge core_clk);
        t++;
      end while (!in_ready && t < 2000);
      hang_if(t);
    end
    in_valid <= 1'b0;
  endtask
  task automatic drain;
    t = 0;
    while (exp_q.size() != 0 && t < 2000) begin
      @(posedge core_clk);
      t++;
    end
    hang_if(t);
    @(posedge core_clk);
  endtask

  // ****************************************
  // reference model, one result per accepted sample
  // ****************************************
  always @(posedge core_clk) begin
    if (!rst && out_valid && out_ready) begin
      if (exp_q.size() == 0) check(56'h1, 56'h0);
      else check({out_ch13, out_ch14, out_ch15, out_ch16}, exp_q.pop_front());
    end
    if (!rst && in_valid && in_ready) begin
      v = '{$signed(in_ch13), $signed(in_ch14), $signed(in_ch15), $signed(in_ch16)};
      for (int i = 0; i < 4; i++) begin
        s = v[i] - xp[i] + yp[i];
        xp[i] = v[i];
        yp[i] = cfg[8'h39][0] ? s - (s >>> cfg[8'h39][4:1]) + (s >>> (2 * cfg[8'h39][4:1])) : 0;
        if (cfg[8'h39][0]) v[i] = sat(yp[i]);
      end
      // one saturation after gain and offset together
      s = cfg[8'h3d][0] ? (v[3] * coef(cfg[8'h37][15:11])) >>> 12 : v[3];
      if (cfg[8'h3d][1]) s = s + $signed(cfg[8'h37][9:0]);
      v[3] = sat(s);
      if (cfg[8'h3d][2]) begin
        for (int i = 0; i < 2; i++) begin
          case (cfg[8'h39][11 - 3 * i -: 3])
            3'h1: v[i] = 0;
            3'h2: v[i] = 16383;
            3'h3: v[i] = ramp[0] ? 14'h1555 : 14'h2aaa;
            3'h4: v[i] = ramp[13:0];
            default: ;
          endcase
        end
        for (int i = 0; i < 4; i++)
          if (cfg[8'h39][15 - i]) v[i] = lfsr[13:0];
      end
      exp_q.push_back({v[0][13:0], v[1][13:0], v[2][13:0], v[3][13:0]});
      ramp++;
      lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    end
  end

  // ****************************************
  // clock and main sequence
  // ****************************************
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  initial begin
    rst = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 16'h0000;
    in_valid = 1'b0;
    {in_ch13, in_ch14, in_ch15, in_ch16} = 56'h0;
    sink_mode = 2'h0;
    seed = 44129;
    bad_count = 0;
    checks_done = 0;
    lfsr = 16'h0001;
    for (int i = 0; i < 256; i++) cfg[i] = 16'h0000;
    #1 rst = 1'b1;
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    cfg[8'h3e] = 16'h0001;
    rd(8'h3e);
    for (int i = 0; i < 5; i++) rd(regs[i]);
    // the last table entry is unmapped: its write must be dropped
    for (int i = 0; i < 5; i++) begin
      wr(regs[i], 16'($random(seed)));
      rd(regs[i]);
    end
    for (int i = 0; i < 5; i++) wr(regs[i], 16'h0000);
    sink_mode <= 2'h1;
    send(40);
    drain;
    sink_mode <= 2'h2;
    send(10);
    repeat (4) @(posedge core_clk);
    #1 check(in_ready, 1'b0);
    // full: fifo count 8, stage and output held, no room
    cfg[8'h3e] = 16'h0046;
    rd(8'h3e);
    sink_mode <= 2'h1;
    drain;
    for (int i = 0; i < 4; i++) begin
      ofs = $random(seed);
      wr(8'h37, {5'(gains[i]), 1'b0, 10'(ofs)});
      wr(8'h38, {6'h00, 10'(ofs)});
      wr(8'h3d, 16'((i < 3) ? i + 1 : 3));
      send(12);
      drain;
    end
    wr(8'h3d, 16'h0000);
    // corner codes kept inside the legal range only
    for (int k = 2; k <= 10; k++) begin
      wr(8'h39, 16'((k << 1) | 1));
      send(8);
      drain;
    end
    wr(8'h3d, 16'h0004);
    // every code written to both coded fields, unused ones included; PRBS enables hide codes 3-5 on out13 and 0, 2, 3, 5 on out14
    for (int c = 0; c < 8; c++) begin
      wr(8'h39, {4'(c * 3), 3'(c), 3'(7 - c), 6'h00});
      send(6);
      drain;
    end
    end_sim;
  end
endmodule
`default_nettype wire
